// *** bench/tcc_chk_sva.sv ***
// Checker for tcc_top: handshake, mode, start level, edges, reset.
// Assumes binding to tcc_top; sees only its ports.
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_chk (
  input wire        CLK,             // Clock
  input wire        RSTN,            // Reset
  input wire [11:0] PADDR,           // Address
  input wire        PSEL,            // Select
  input wire        PENABLE,         // Enable
  input wire        PWRITE,          // Direction
  input wire [31:0] PWDATA,          // Write data
  input wire        PREADY,          // Ready
  input wire        PSLVERR,         // Error
  input wire        DEMOD_MODE,      // Mode
  input wire        LONG_INIT_LEVEL, // Start level
  input wire        POS_EDGE,        // Rising pulse
  input wire        NEG_EDGE,        // Falling pulse
  input wire        IRQ              // Interrupt
);
  wire wr_ctrl;
  assign wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && PADDR == `TCC_CTRL_ADDR;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_mode_write: assert property (wr_ctrl |-> ##2 DEMOD_MODE == $past(PWDATA[7], 2))
    else $error("mode not written");
  a_init_write: assert property (wr_ctrl && !PWDATA[7] && !$past(DEMOD_MODE, 3)
    |-> ##2 LONG_INIT_LEVEL == $past(PWDATA[0], 2)) else $error("start level wrong");
  a_edge_mode: assert property (POS_EDGE || NEG_EDGE |-> DEMOD_MODE || $past(DEMOD_MODE))
    else $error("edge outside demod");
  a_pos_single: assert property (POS_EDGE |=> !POS_EDGE)
    else $error("rise pulse long");
  a_neg_single: assert property ($rose(NEG_EDGE) |=> $fell(NEG_EDGE))
    else $error("fall pulse long");
  a_reset_quiet: assert property (@(posedge CLK) disable iff (1'b0)
    !RSTN |=> !PREADY && !DEMOD_MODE && !IRQ && !POS_EDGE) else $error("reset outputs");
  cover property (wr_ctrl && PWDATA[7]);
  cover property (POS_EDGE);
  cover property (PSLVERR);
  cover property (IRQ);
endmodule // tcc_chk

// *** bench/tcc_pin_model.sv ***
// Model of the outside pins feeding the demodulator.
// Assumes the bench calls pulse; pins idle low.
`timescale 1ns/1ps
module tcc_pin_model (
  input  wire clk,     // System clock
  output reg  pri_pin, // Primary pin
  output reg  alt_pin  // Alternate pin
);
  initial begin
    pri_pin = 1'b0;
    alt_pin = 1'b0;
  end
  task pulse(input a, input integer w);
    begin
      @(posedge clk);
      if (a)
        alt_pin <= 1'b1;
      else
        pri_pin <= 1'b1;
      repeat (w) @(posedge clk);
      alt_pin <= 1'b0;
      pri_pin <= 1'b0;
    end
  endtask
endmodule // tcc_pin_model

// *** bench/test_dual_timer_common_control.sv ***
// Testbench for tcc_top over APB, with the pin model.
// Assumes tcc_top, tcc_pin_model and tcc_chk compiled first.
`timescale 1ns/1ps
`include "tcc_map.vh"
module test_dual_timer_common_control;
  reg         clk = 1'b0, rstn = 1'b0, stop_n = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [3:0]  drv = 4'h0;
  reg         er;
  wire [31:0] prdata;
  wire        pready, pslverr, pin, lvl16, lvl8, dm, pe, ne, irq, pri, alt;
  integer     errors = 0, n_tests = 0, npos = 0, nneg = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (pe === 1'b1)
      npos <= npos + 1;
    if (ne === 1'b1)
      nneg <= nneg + 1;
  end
  tcc_top u_tcc_top (.CLK(clk), .RSTN(rstn), .STOP_RECOVER_N(stop_n), .PADDR(paddr),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SHORT_TIMER_OUTPUT(drv[0]),
    .LONG_TIMER_OUTPUT(drv[1]), .PING_PONG_SEL(drv[2]), .PORT_OUT_DATA(drv[3]),
    .PRIMARY_DEMOD_INPUT_PIN(pri), .ALTERNATE_DEMOD_INPUT_PIN(alt),
    .SHARED_OUTPUT_PIN(pin), .LONG_INIT_LEVEL(lvl16), .SHORT_INIT_LEVEL(lvl8),
    .DEMOD_MODE(dm), .POS_EDGE(pe), .NEG_EDGE(ne), .IRQ(irq));
  tcc_pin_model u_tcc_pin_model (.clk(clk), .pri_pin(pri), .alt_pin(alt));
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
        errors = errors + 1;
      end
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwr <= w;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
        errors = errors + 1;
        end_sim;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task tx(input [7:0] c, input [3:0] s, input e);
    begin
      apb(`TCC_CTRL_ADDR, 1'b1, {24'h0, c});
      drv <= s;
      repeat (3) @(posedge clk);
      chk("pin", {31'h0, e}, {31'h0, pin});
    end
  endtask
  task demod(input [7:0] c, input a, input integer w, input ep, input en);
    integer p0, n0;
    begin
      apb(`TCC_CTRL_ADDR, 1'b1, {24'h0, c | 8'h03});
      p0 = npos;
      n0 = nneg;
      u_tcc_pin_model.pulse(a, w);
      repeat (20) @(posedge clk);
      chk("rises", {31'h0, ep}, npos - p0);
      chk("falls", {31'h0, en}, nneg - n0);
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("flags", {24'h0, c[7:2], ep, en}, rd);
    end
  endtask
  task t_tx;
    integer l, c;
    reg e;
    begin
      tx(8'h03, 4'h0, 1'b0);
      chk("start16", 1, {31'h0, lvl16});
      chk("start8", 1, {31'h0, lvl8});
      tx(8'h00, 4'h8, 1'b1);
      for (l = 0; l < 4; l = l + 1)
        for (c = 0; c < 4; c = c + 1) begin
          e = l == 0 ? c == 3 : l == 1 ? c != 0 : l == 2 ? c == 0 : c != 3;
          tx({2'b01, l[1:0], 4'h0}, c[3:0], e);
        end
      tx(8'h48, 4'h3, 1'b0);
      tx(8'h4c, 4'h1, 1'b1);
      tx(8'h44, 4'h6, 1'b1);
      tx(8'h44, 4'h2, 1'b0);
      $display("transmit done");
    end
  endtask
  task t_demod;
    integer m;
    begin
      for (m = 3; m >= 0; m = m - 1)
        demod({2'b10, m[1:0], 4'h0}, 1'b0, 12, m == 1 || m == 2, m == 0 || m == 2);
      apb(`TCC_CTRL_ADDR, 1'b1, 32'h80);
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("flag kept", 32'h81, rd);
      apb(`TCC_CTRL_ADDR, 1'b1, 32'h81);
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("flag clear", 32'h80, rd);
      demod(8'ha0, 1'b0, 1, 1'b1, 1'b1);
      demod(8'ha4, 1'b0, 3, 1'b0, 1'b0);
      demod(8'ha4, 1'b0, 4, 1'b1, 1'b1);
      demod(8'ha8, 1'b0, 7, 1'b0, 1'b0);
      demod(8'ha8, 1'b0, 8, 1'b1, 1'b1);
      demod(8'he0, 1'b1, 4, 1'b1, 1'b1);
      demod(8'he0, 1'b0, 4, 1'b0, 1'b0);
      apb(`TCC_CTRL_ADDR, 1'b1, 32'h93);
      fork
        u_tcc_pin_model.pulse(1'b0, 6);
        begin
          repeat (2) @(posedge clk);
          apb(`TCC_CTRL_ADDR, 1'b1, 32'h93);
        end
      join
      repeat (20) @(posedge clk);
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("race flag", 32'h92, rd);
      $display("demod done");
    end
  endtask
  task t_irq;
    begin
      apb(`TCC_ISTAT_ADDR, 1'b0, 32'h0);
      apb(`TCC_IMASK_ADDR, 1'b1, 32'h0);
      demod(8'ha0, 1'b0, 6, 1'b1, 1'b1);
      chk("irq off", 0, {31'h0, irq});
      apb(`TCC_ISTAT_ADDR, 1'b0, 32'h0);
      chk("status", 3, rd);
      apb(`TCC_IMASK_ADDR, 1'b1, 32'h2);
      demod(8'ha0, 1'b0, 6, 1'b1, 1'b1);
      chk("irq on", 1, {31'h0, irq});
      apb(`TCC_ISTAT_ADDR, 1'b0, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq low", 0, {31'h0, irq});
      apb(12'h020, 1'b1, 32'hff);
      chk("bad err", 1, {31'h0, er});
      apb(12'h020, 1'b0, 32'h0);
      chk("bad data", 0, rd);
      $display("irq done");
    end
  endtask
  task t_stop;
    begin
      apb(`TCC_CTRL_ADDR, 1'b1, 32'h7f);
      stop_n <= 1'b0;
      @(posedge clk);
      stop_n <= 1'b1;
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("stop", 32'h30, rd);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(`TCC_CTRL_ADDR, 1'b0, 32'h0);
      chk("reset", 32'h0, rd);
      chk("mode", 0, {31'h0, dm});
      $display("reset done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_tx;
    t_demod;
    t_irq;
    t_stop;
    end_sim;
  end
endmodule // test_dual_timer_common_control
bind tcc_top tcc_chk u_tcc_chk (.CLK(CLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DEMOD_MODE(DEMOD_MODE), .LONG_INIT_LEVEL(LONG_INIT_LEVEL), .POS_EDGE(POS_EDGE),
  .NEG_EDGE(NEG_EDGE), .IRQ(IRQ));

// *** core/tcc_filt.v ***
// Glitch filter: output follows input only after it is stable long enough.
// Assumes a synchronised input on the CLK domain.
`timescale 1ns/1ps
module tcc_filt #(
  parameter CW = 4
) (
  input  wire          clk,    // System clock
  input  wire          rstn,   // Sync reset, active low
  input  wire          din,    // Synchronised input
  input  wire [CW-1:0] len,    // Needed stable cycles, 0 = bypass
  output wire          dout    // Filtered level
);
  reg          out_r;
  reg [CW-1:0] cnt_r;
  always @(posedge clk) begin
    if (!rstn) begin
      out_r <= 1'b0;
      cnt_r <= {CW{1'b0}};
    end else if (len == {CW{1'b0}}) begin
      out_r <= din;
      cnt_r <= {CW{1'b0}};
    end else if (din == out_r) begin
      cnt_r <= {CW{1'b0}};
    end else if (cnt_r + 1'b1 >= len) begin
      out_r <= din;
      cnt_r <= {CW{1'b0}};
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign dout = out_r;
endmodule // tcc_filt

// *** core/tcc_map.vh ***
// Constants for the dual timer common control block.
// Assumes inclusion by bare name from the core files.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, index times four)
// ----------------------------------------------------------------------
`define TCC_CTRL_INDEX      8'h01
`define TCC_CTRL_ADDR       12'h004
`define TCC_ISTAT_ADDR      12'h010
`define TCC_IMASK_ADDR      12'h014
// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define TCC_MODE_BIT        7
`define TCC_ROUTE_BIT       6
`define TCC_LOGIC_HI        5
`define TCC_LOGIC_LO        4
`define TCC_OPT_HI          3
`define TCC_OPT_LO          2
`define TCC_B1_BIT          1
`define TCC_B0_BIT          0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TCC_CTRL_RST        8'h00
`define TCC_IRQ_RST         2'h0
// ----------------------------------------------------------------------
// Filter timing (clock at 100 MHz)
// ----------------------------------------------------------------------
`define TCC_FILT_SHORT      4'h4
`define TCC_FILT_LONG       4'h8
`endif

// *** core/tcc_sync.v ***
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes pins are asynchronous to CLK.
`timescale 1ns/1ps
module tcc_sync #(
  parameter W = 2
) (
  input  wire         clk,    // System clock
  input  wire         rstn,   // Sync reset, active low
  input  wire [W-1:0] d,      // Async inputs
  output wire [W-1:0] q       // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge clk) begin
    if (!rstn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
  assign q = sync_r;
endmodule // tcc_sync

// *** core/tcc_top.v ***
// Common control of the eight- and sixteen-bit timers, APB slave.
// Assumes timer outputs arrive on CLK; demod pins are asynchronous.
// Operation
// - Mode bit: 0 transmit (reset), 1 demodulation; other fields depend on it.
// - Transmit: bit sets sixteen-bit timer output start level, reset 0.
// - Transmit: bit sets eight-bit timer output start level, reset 0.
// - Demod: sticky falling-edge flag; write 1 clears, 0 no effect.
// - Demod: sticky rising-edge flag; write 1 clears, 0 no effect.
// - Transmit: 00 normal, 01 ping-pong, 10 force low, 11 force high.
// - Demod: filter 00 none, 01 four cycles, 10 eight cycles, 11 reserved.
// - Transmit: combine timer outputs 00 AND, 01 OR, 10 NOR, 11 NAND.
// - Demod: edges 00 falling, 01 rising, 10 both, 11 reserved.
// - Transmit: route bit 0 port output, 1 combined timer output on pin.
// - Demod: route bit 0 primary input pin, 1 alternate input pin.
// - Reset defaults apply; logic field survives stop recovery, cleared on full reset.
// - Edge detector pulses on edges chosen by bits 5 and 4.
// - Filter drops pulses narrower than bits 3 and 2 select, before edges.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_top (
  input  wire        CLK,          // System clock, 100 MHz
  input  wire        RSTN,         // Full reset, sync, active low
  input  wire        STOP_RECOVER_N, // Stop-mode recovery reset, active low
  input  wire [11:0] PADDR,        // APB address
  input  wire        PSEL,         // APB select
  input  wire        PENABLE,      // APB enable
  input  wire        PWRITE,       // APB direction
  input  wire [31:0] PWDATA,       // APB write data
  output reg  [31:0] PRDATA,       // APB read data
  output reg         PREADY,       // APB ready
  output reg         PSLVERR,      // APB error
  input  wire        SHORT_TIMER_OUTPUT, // Eight-bit timer output
  input  wire        LONG_TIMER_OUTPUT,  // Sixteen-bit timer output
  input  wire        PING_PONG_SEL, // Ping-pong: 1 selects sixteen-bit timer
  input  wire        PORT_OUT_DATA, // Ordinary port data for shared pin
  input  wire        PRIMARY_DEMOD_INPUT_PIN,   // Demod input pin
  input  wire        ALTERNATE_DEMOD_INPUT_PIN, // Alternate demod pin
  output reg         SHARED_OUTPUT_PIN, // Shared output pin level
  output reg         LONG_INIT_LEVEL,   // Sixteen-bit timer start level
  output reg         SHORT_INIT_LEVEL,  // Eight-bit timer start level
  output reg         DEMOD_MODE,        // High in demodulation mode
  output reg         POS_EDGE,          // Rising edge pulse
  output reg         NEG_EDGE,          // Falling edge pulse
  output reg         IRQ                // Interrupt, level, active high
);
  // ----------------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------------
  localparam [1:0] OPT_NORMAL = 2'h0;
  localparam [1:0] OPT_PING   = 2'h1;
  localparam [1:0] OPT_LOW    = 2'h2;
  localparam [1:0] OPT_HIGH   = 2'h3;
  localparam [1:0] FLT_NONE   = 2'h0;
  localparam [1:0] FLT_SHORT  = 2'h1;
  localparam [1:0] FLT_LONG   = 2'h2;
  localparam [1:0] CMB_AND    = 2'h0;
  localparam [1:0] CMB_OR     = 2'h1;
  localparam [1:0] CMB_NOR    = 2'h2;
  localparam [1:0] CMB_NAND   = 2'h3;
  localparam [1:0] EDG_FALL   = 2'h0;
  localparam [1:0] EDG_RISE   = 2'h1;
  localparam [1:0] EDG_BOTH   = 2'h2;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  reg  [7:0] ctrl_r;
  reg        fall_flag_r;
  reg        rise_flag_r;
  reg  [1:0] istat_r;
  reg  [1:0] imask_r;
  // Field views of the control register
  wire       mode   = ctrl_r[`TCC_MODE_BIT];
  wire       route  = ctrl_r[`TCC_ROUTE_BIT];
  wire [1:0] logic_sel = ctrl_r[`TCC_LOGIC_HI:`TCC_LOGIC_LO];
  wire [1:0] opt    = ctrl_r[`TCC_OPT_HI:`TCC_OPT_LO];

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // Edge select: 00 falling, 01 rising, 10 both, 11 none
  function edge_on;
    input [1:0] sel;
    input       rising;
    begin
      case (sel)
        EDG_FALL: edge_on = !rising;
        EDG_RISE: edge_on = rising;
        EDG_BOTH: edge_on = 1'b1;
        default:  edge_on = 1'b0;
      endcase
    end
  endfunction

  // Access phase taken once; ready answers one cycle later
  wire acc     = PSEL && PENABLE && !PREADY;
  wire wr      = acc && PWRITE;
  wire rd      = acc && !PWRITE;
  wire hit_ctl = is_addr(PADDR, `TCC_CTRL_ADDR);
  wire hit_sta = is_addr(PADDR, `TCC_ISTAT_ADDR);
  wire hit_msk = is_addr(PADDR, `TCC_IMASK_ADDR);
  wire mapped  = hit_ctl || hit_sta || hit_msk;

  // ----------------------------------------------------------------------
  // Demodulator input path
  // ----------------------------------------------------------------------
  wire [1:0] pins_s;
  wire       filt;
  reg        filt_d_r;
  reg  [3:0] flen;
  // Both pins synchronised so a route change sees settled levels
  tcc_sync #(.W(2)) u_sync (
    .clk  (CLK),
    .rstn (RSTN),
    .d    ({ALTERNATE_DEMOD_INPUT_PIN, PRIMARY_DEMOD_INPUT_PIN}),
    .q    (pins_s)
  );
  wire demod_in = route ? pins_s[1] : pins_s[0];

  always @* begin
    case (opt)
      FLT_NONE:  flen = 4'h0;
      FLT_SHORT: flen = `TCC_FILT_SHORT;
      FLT_LONG:  flen = `TCC_FILT_LONG;
      default:   flen = 4'h0;
    endcase
  end

  // Filter only acts in demod mode
  tcc_filt #(.CW(4)) u_filt (
    .clk  (CLK),
    .rstn (RSTN),
    .din  (demod_in),
    .len  (mode ? flen : 4'h0),
    .dout (filt)
  );

  // ----------------------------------------------------------------------
  // Edge detection on the filtered level
  // ----------------------------------------------------------------------
  wire rise_raw = filt && !filt_d_r;
  wire fall_raw = !filt && filt_d_r;
  wire rise_ev  = mode && rise_raw && edge_on(logic_sel, 1'b1);
  wire fall_ev  = mode && fall_raw && edge_on(logic_sel, 1'b0);

  // ----------------------------------------------------------------------
  // Transmit output combining
  // ----------------------------------------------------------------------
  reg comb;
  reg tx_out;
  always @* begin
    case (logic_sel)
      CMB_AND:  comb = SHORT_TIMER_OUTPUT & LONG_TIMER_OUTPUT;
      CMB_OR:   comb = SHORT_TIMER_OUTPUT | LONG_TIMER_OUTPUT;
      CMB_NOR:  comb = ~(SHORT_TIMER_OUTPUT | LONG_TIMER_OUTPUT);
      CMB_NAND: comb = ~(SHORT_TIMER_OUTPUT & LONG_TIMER_OUTPUT);
      default:  comb = SHORT_TIMER_OUTPUT & LONG_TIMER_OUTPUT;
    endcase
  end
  always @* begin
    case (opt)
      OPT_NORMAL: tx_out = comb;
      OPT_PING:   tx_out = PING_PONG_SEL ? LONG_TIMER_OUTPUT : SHORT_TIMER_OUTPUT;
      OPT_LOW:    tx_out = 1'b0;
      OPT_HIGH:   tx_out = 1'b1;
      default:    tx_out = comb;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------------
  wire       wr_ctl = wr && hit_ctl;
  wire [1:0] ev     = {rise_ev, fall_ev};
  reg  [7:0] ctrl_nxt;
  reg        fall_flag_nxt;
  reg        rise_flag_nxt;
  reg  [1:0] istat_nxt;
  reg  [1:0] imask_nxt;
  reg [31:0] prdata_nxt;
  reg        pin_nxt;
  reg        irq_nxt;

  // Control register: stop recovery spares the logic field
  always @* begin
    ctrl_nxt = ctrl_r;
    if (!STOP_RECOVER_N) begin
      ctrl_nxt[`TCC_MODE_BIT]           = 1'b0;
      ctrl_nxt[`TCC_ROUTE_BIT]          = 1'b0;
      ctrl_nxt[`TCC_OPT_HI:`TCC_OPT_LO] = 2'h0;
      ctrl_nxt[`TCC_B1_BIT]             = 1'b0;
      ctrl_nxt[`TCC_B0_BIT]             = 1'b0;
    end else if (wr_ctl) begin
      ctrl_nxt[7:2] = PWDATA[7:2];
      // Demod writes leave the stored start levels alone
      if (!PWDATA[`TCC_MODE_BIT]) begin
        ctrl_nxt[1:0] = PWDATA[1:0];
      end
    end
  end

  // Sticky edge flags: set wins over write-one clear
  always @* begin
    fall_flag_nxt = fall_flag_r;
    rise_flag_nxt = rise_flag_r;
    if (fall_ev) begin
      fall_flag_nxt = 1'b1;
    end else if (wr_ctl && PWDATA[`TCC_B0_BIT]) begin
      fall_flag_nxt = 1'b0;
    end
    if (rise_ev) begin
      rise_flag_nxt = 1'b1;
    end else if (wr_ctl && PWDATA[`TCC_B1_BIT]) begin
      rise_flag_nxt = 1'b0;
    end
  end

  // Status clears on read; an event in the read cycle is kept
  always @* begin
    imask_nxt = imask_r;
    istat_nxt = istat_r | ev;
    if (wr && hit_msk) begin
      imask_nxt = PWDATA[1:0];
    end
    if (rd && hit_sta) begin
      istat_nxt = ev;
    end
  end

  // Read data: demod control reads show the flags in bits 1:0
  always @* begin
    prdata_nxt = 32'h0;
    if (rd && hit_ctl) begin
      prdata_nxt[7:0] = mode ? {ctrl_r[7:2], rise_flag_r, fall_flag_r} : ctrl_r;
    end else if (rd && hit_sta) begin
      prdata_nxt[1:0] = istat_r;
    end else if (rd && hit_msk) begin
      prdata_nxt[1:0] = imask_r;
    end
  end

  // Pin and interrupt next values
  always @* begin
    pin_nxt = PORT_OUT_DATA;
    if (!mode && route) begin
      pin_nxt = tx_out;
    end
    irq_nxt = |(istat_r & imask_r);
  end

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_r      <= `TCC_CTRL_RST;
      fall_flag_r <= 1'b0;
      rise_flag_r <= 1'b0;
      istat_r     <= `TCC_IRQ_RST;
      imask_r     <= `TCC_IRQ_RST;
      filt_d_r    <= 1'b0;
      PRDATA      <= 32'h0;
      PREADY      <= 1'b0;
      PSLVERR     <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      fall_flag_r <= fall_flag_nxt;
      rise_flag_r <= rise_flag_nxt;
      istat_r     <= istat_nxt;
      imask_r     <= imask_nxt;
      filt_d_r    <= filt;
      PRDATA      <= prdata_nxt;
      PREADY      <= acc;
      PSLVERR     <= acc && !mapped;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RSTN) begin
      SHARED_OUTPUT_PIN <= 1'b0;
      LONG_INIT_LEVEL   <= 1'b0;
      SHORT_INIT_LEVEL  <= 1'b0;
      DEMOD_MODE        <= 1'b0;
      POS_EDGE          <= 1'b0;
      NEG_EDGE          <= 1'b0;
      IRQ               <= 1'b0;
    end else begin
      SHARED_OUTPUT_PIN <= pin_nxt;
      LONG_INIT_LEVEL   <= ctrl_r[`TCC_B0_BIT];
      SHORT_INIT_LEVEL  <= ctrl_r[`TCC_B1_BIT];
      DEMOD_MODE        <= mode;
      POS_EDGE          <= rise_ev;
      NEG_EDGE          <= fall_ev;
      IRQ               <= irq_nxt;
    end
  end
endmodule // tcc_top
